// file: design/core_exec_defs.svh
// constants for the instruction execute slice and reset timers
`ifndef CORE_EXEC_DEFS_SVH
`define CORE_EXEC_DEFS_SVH
`define CLK_FREQ_HZ 50000000
`define TIMEOUT_TYP_MS 18
`define TIMEOUT_CYCLES ((`CLK_FREQ_HZ / 1000) * `TIMEOUT_TYP_MS)
`define OP_SWAP_HI 6'h0e
`define OP_SUB_HI 6'h02
`define OP_DIRLOAD_HI 9'h000
`define DIR_SEL_A 3'h5
`define DIR_SEL_B 3'h6
`define DIR_SEL_C 3'h7
`define BYTE_ZERO 8'h00
`define BYTE_ONES 8'hff
`define FLAG_C 0
`define FLAG_DC 1
`define FLAG_Z 2
`endif

// file: design/core_exec_pkg.sv
// types for the instruction execute slice
package core_exec_pkg;
  typedef enum logic [1:0] {st_hold, st_count, st_run} reset_state_t;
endpackage

// file: design/reset_timer.sv
// timeout counter shared by the reset delay and watchdog
`timescale 1ns/1ps
`default_nettype none
`include "core_exec_defs.svh"
module reset_timer #(
  parameter int unsigned COUNT = `TIMEOUT_CYCLES
) (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic clear_in, // restart the count
  input wire logic run_in, // count while high
  output logic done_out // one-cycle timeout pulse
);
  typedef struct packed {
    logic [31:0] cnt;
    logic done;
  } timer_state_t;
  timer_state_t s_reg;
  timer_state_t s_next;
  // count to the limit then pulse and wrap
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (clear_in)
    begin
      s_next.cnt = 32'h0;
    end
    else if (run_in)
    begin
      if (s_reg.cnt >= COUNT - 1)
      begin
        s_next.cnt = 32'h0;
        s_next.done = 1'b1;
      end
      else
      begin
        s_next.cnt = s_reg.cnt + 32'h1;
      end
    end
  end
  // state register
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
  assign done_out = s_reg.done;
endmodule
`default_nettype wire

// file: design/nibble_swap_port_direction_load_instr_subtract_exec.sv
// execute slice: nibble swap, direction load, subtract, reset timers
`timescale 1ns/1ps
`default_nettype none
`include "core_exec_defs.svh"
module nibble_swap_port_direction_load_instr_subtract_exec
  import core_exec_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
  input wire logic clk_in, // 50 MHz system clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic master_clear_input_in, // pin, active high run
  input wire logic instr_valid_in, // instruction present this cycle
  input wire logic [11:0] instr_in, // 12-bit opcode
  input wire logic [7:0] file_rdata_in, // addressed file register value
  input wire logic wdt_enable_in, // watchdog running
  input wire logic wdt_clear_in, // watchdog restart
  output logic [4:0] file_addr_out, // file register address
  output logic [7:0] file_wdata_out, // file write data
  output logic file_we_out, // file write strobe
  output logic [7:0] acc_out, // working register
  output logic [2:0] flags_out, // z, digit carry, carry
  output logic [7:0] dir_a_out, // direction register 5
  output logic [7:0] dir_b_out, // direction register 6
  output logic [7:0] dir_c_out, // direction register 7
  output logic core_reset_out, // internal reset active
  output logic wdt_timeout_out // watchdog timeout pulse
);
  // ==========================================================
  // state record: every flop of the slice outside the two timers
  typedef struct packed {
    logic [1:0] master_clear_input_sync;
    reset_state_t rst_st;
    logic [7:0] acc;
    logic [2:0] flags;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
    logic [4:0] faddr;
    logic [7:0] fwdata;
    logic fwe;
    logic wdt_to;
    logic in_rst;
  } exec_state_t;
  exec_state_t s_reg;
  exec_state_t s_next;
  // timer pulses and decoded instruction
  logic drt_done;
  logic wdt_done;
  logic [8:0] sub_res;
  logic [4:0] sub_low;
  logic [7:0] result;
  logic is_swap;
  logic is_sub;
  logic is_dir;

  // exchange the two halves of a byte
  // shared by the swap path to acc and to the file
  function automatic logic [7:0] swap_nibbles(input logic [7:0] v);
    swap_nibbles = {v[3:0], v[7:4]};
  endfunction

  // ==========================================================
  // reset delay timer and watchdog
  // the delay timer is held clear outside the count state, so a
  // master clear glitch restarts the full delay instead of resuming
  // the watchdog is held clear while the core sits in reset, so it
  // always starts a fresh period once the core runs
  // both share one length: the typical period at the system clock
  reset_timer #(
    .COUNT(TIMEOUT_CYCLES)
  ) drt_inst (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(s_reg.rst_st != st_count),
    .run_in(s_reg.rst_st == st_count),
    .done_out(drt_done)
  );
  reset_timer #(
    .COUNT(TIMEOUT_CYCLES)
  ) wdt_inst (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(wdt_clear_in || s_reg.rst_st != st_run),
    .run_in(wdt_enable_in),
    .done_out(wdt_done)
  );

  // ==========================================================
  // decode and arithmetic
  // subtract works on nine and five bit copies so the top bit is the
  // borrow out of the byte and of the low nibble; carry and digit
  // carry are their inverses
  // an unlisted direction selector decodes as nothing at all
  // swap and subtract share one result path and one destination bit
  assign is_swap = instr_in[11:6] == `OP_SWAP_HI;
  assign is_sub = instr_in[11:6] == `OP_SUB_HI;
  assign is_dir = instr_in[11:3] == `OP_DIRLOAD_HI && instr_in[2:0] >= `DIR_SEL_A;
  assign sub_res = {1'b0, file_rdata_in} - {1'b0, s_reg.acc};
  assign sub_low = {1'b0, file_rdata_in[3:0]} - {1'b0, s_reg.acc[3:0]};
  assign result = is_swap ? swap_nibbles(file_rdata_in) : sub_res[7:0];

  // ==========================================================
  // next state
  // the master clear pin passes two flops before the state machine
  // reads it; only the second flop is looked at
  // in the run state a low master clear or a watchdog timeout wins
  // over any instruction presented in the same cycle
  // instructions seen in hold or count are dropped; only the file address follows them
  always_comb
  begin
    s_next = s_reg;
    s_next.master_clear_input_sync = {s_reg.master_clear_input_sync[0], master_clear_input_in};
    s_next.fwe = 1'b0;
    s_next.wdt_to = wdt_done;
    s_next.faddr = instr_in[4:0];
    case (s_reg.rst_st)
      st_hold:
      begin
        if (s_reg.master_clear_input_sync[1])
        begin
          s_next.rst_st = st_count;
        end
      end
      st_count:
      begin
        if (!s_reg.master_clear_input_sync[1])
        begin
          s_next.rst_st = st_hold;
        end
        else if (drt_done)
        begin
          s_next.rst_st = st_run;
        end
      end
      st_run:
      begin
        if (!s_reg.master_clear_input_sync[1] || wdt_done)
        begin
          s_next.rst_st = st_hold;
        end
        else if (instr_valid_in && (is_swap || is_sub))
        begin
          if (instr_in[5])
          begin
            s_next.fwe = 1'b1;
            s_next.fwdata = result;
          end
          else
          begin
            s_next.acc = result;
          end
          if (is_sub)
          begin
            s_next.flags[`FLAG_C] = ~sub_res[8];
            s_next.flags[`FLAG_DC] = ~sub_low[4];
            s_next.flags[`FLAG_Z] = sub_res[7:0] == `BYTE_ZERO;
          end
        end
        else if (instr_valid_in && is_dir)
        begin
          case (instr_in[2:0])
            `DIR_SEL_A: s_next.dir_a = s_reg.acc;
            `DIR_SEL_B: s_next.dir_b = s_reg.acc;
            default: s_next.dir_c = s_reg.acc;
          endcase
        end
      end
      default:
      begin
        s_next.rst_st = st_hold;
      end
    endcase
    // reset flag is registered so the port comes straight from a flop
    s_next.in_rst = s_next.rst_st != st_run;
  end

  // ==========================================================
  // state register
  // reset puts the core in hold with all direction bits set to input
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      s_reg <= '0;
      s_reg.rst_st <= st_hold;
      s_reg.in_rst <= 1'b1;
      s_reg.dir_a <= `BYTE_ONES;
      s_reg.dir_b <= `BYTE_ONES;
      s_reg.dir_c <= `BYTE_ONES;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs straight from flops
  // the file write strobe stands for one cycle only; the outside
  // must take the write on that edge, there is no retry
  // the reset flag stays high from hold until the delay runs out
  assign file_addr_out = s_reg.faddr;
  assign file_wdata_out = s_reg.fwdata;
  assign file_we_out = s_reg.fwe;
  assign acc_out = s_reg.acc;
  assign flags_out = s_reg.flags;
  assign dir_a_out = s_reg.dir_a;
  assign dir_b_out = s_reg.dir_b;
  assign dir_c_out = s_reg.dir_c;
  assign core_reset_out = s_reg.in_rst;
  assign wdt_timeout_out = s_reg.wdt_to;
endmodule
`default_nettype wire

// file: tb/exec_checker_asserts.sv
// port assertions for the execute slice
`timescale 1ns/1ps
`default_nettype none
module exec_checker #(parameter int unsigned TIMEOUT_CYCLES = 20) (
  input wire logic clk_in, rst_n_in, master_clear_input_in, instr_valid_in, wdt_enable_in, wdt_clear_in,
  input wire logic [11:0] instr_in,
  input wire logic [7:0] file_rdata_in, file_wdata_out, acc_out, dir_a_out, dir_b_out, dir_c_out,
  input wire logic [4:0] file_addr_out,
  input wire logic [2:0] flags_out,
  input wire logic file_we_out, core_reset_out, wdt_timeout_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] rd_q, acc_q;
  logic [11:0] ins_q;
  int unsigned hi_cnt;
  wire tk = instr_valid_in && !core_reset_out;
  wire sw = tk && instr_in[11:6] == 6'h0e;
  wire sb = tk && instr_in[11:6] == 6'h02;
  // last-cycle copies and master clear high run length in reset
  always_ff @(posedge clk_in)
  begin
    rd_q <= file_rdata_in;
    acc_q <= acc_out;
    ins_q <= instr_in;
    hi_cnt <= (rst_n_in && master_clear_input_in && core_reset_out) ? hi_cnt + 1 : 0;
  end
  // ==========================================
  // assertions
  a_swap_to_acc: assert property (sw && !instr_in[5] |=> acc_out == {rd_q[3:0], rd_q[7:4]})
    else $error("swap to acc wrong");
  a_swap_flags_kept: assert property (sw |=> $stable(flags_out))
    else $error("swap changed flags");
  a_swap_to_file: assert property (sw && instr_in[5] |=> file_we_out && file_addr_out == ins_q[4:0] && file_wdata_out == {rd_q[3:0], rd_q[7:4]})
    else $error("swap to file wrong");
  a_dir_a_load: assert property (tk && instr_in == 12'h005 |=> dir_a_out == acc_q)
    else $error("dir a load wrong");
  a_dir_c_load: assert property (tk && instr_in == 12'h007 |=> dir_c_out == acc_q)
    else $error("dir c load wrong");
  a_dir_illegal_kept: assert property (tk && instr_in == 12'h004 |=> $stable({dir_a_out, dir_b_out, dir_c_out}))
    else $error("illegal dir load acted");
  a_sub_borrow_flags: assert property (sb |=> flags_out[0] == (rd_q >= acc_q) && flags_out[1] == (rd_q[3:0] >= acc_q[3:0]))
    else $error("subtract carry wrong");
  a_master_clear_input_low_reset: assert property (!master_clear_input_in |-> ##[1:3] core_reset_out)
    else $error("master clear low ignored");
  a_reset_release: assert property ($fell(core_reset_out) |-> hi_cnt >= TIMEOUT_CYCLES && hi_cnt <= TIMEOUT_CYCLES + 8)
    else $error("reset delay length wrong");
  a_wdt_reenter: assert property (wdt_timeout_out |=> core_reset_out)
    else $error("watchdog did not reset");
  a_dir_b_load: assert property (tk && instr_in == 12'h006 |=> dir_b_out == acc_q)
    else $error("dir b load wrong");
  a_sub_zero_flag: assert property (sb |=> flags_out[2] == (rd_q == acc_q))
    else $error("subtract zero flag wrong");
  a_sub_to_file: assert property (sb && instr_in[5] |=> file_we_out && file_wdata_out == rd_q - acc_q)
    else $error("subtract to file wrong");
  a_acc_not_file: assert property (sw && instr_in[5] |=> acc_out == acc_q)
    else $error("file write moved acc");
  c_dir_load: cover property (tk && instr_in[11:3] == 9'h000 && instr_in[2:0] >= 3'h5);
  c_swap_file: cover property (sw && instr_in[5]);
  c_sub: cover property (sb);
  c_wdt: cover property (wdt_timeout_out);
endmodule
bind nibble_swap_port_direction_load_instr_subtract_exec exec_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.*);
`default_nettype wire

// file: tb/tb_nibble_swap_port_direction_load_instr_subtract_exec.sv
// self-checking bench for the execute slice
`timescale 1ns/1ps
`default_nettype none
module tb_nibble_swap_port_direction_load_instr_subtract_exec;
  localparam int unsigned TO = 20;
  logic clk_in = 0, rst_n_in = 0, master_clear_input_in = 0, instr_valid_in = 0, wdt_enable_in = 0, wdt_clear_in = 0;
  logic [11:0] instr_in = 0, e;
  logic [7:0] file_rdata_in = 0, file_wdata_out, acc_out, dir_a_out, dir_b_out, dir_c_out, acc_m = 0, r, b, g;
  logic [4:0] file_addr_out;
  logic [2:0] flags_out, flags_m = 0;
  logic file_we_out, core_reset_out, wdt_timeout_out;
  logic [31:0] seed = 32'h056e17cb;
  int errors = 0, checks = 0, cyc = 0, n = 0;
  logic [11:0] q[$]; // kind in [11:8], value in [7:0]
  nibble_swap_port_direction_load_instr_subtract_exec #(.TIMEOUT_CYCLES(TO)) u_dut (.*);
  always #10 clk_in = ~clk_in;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic void ex(input logic [3:0] s, input logic [7:0] v);
    q.push_back({s, v});
  endfunction
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic op(input logic [11:0] ins, input logic [7:0] rd);
    @(posedge clk_in);
    instr_in <= ins;
    file_rdata_in <= rd;
    instr_valid_in <= 1;
    @(posedge clk_in);
    instr_valid_in <= 0;
  endtask
  task automatic wait_run();
    n = 0;
    while (core_reset_out !== 1'b0 && n < 200)
    begin
      @(negedge clk_in);
      n++;
    end
  endtask
  // ==========================================
  // monitor: every queued note against settled outputs
  always @(negedge clk_in)
  begin
    cyc++;
    if (cyc > 6000)
    begin
      errors++;
      tally_and_finish();
    end
    while (q.size() > 0)
    begin
      e = q.pop_front();
      case (e[11:8])
        0: g = acc_out;
        1: g = file_we_out ? file_wdata_out : ~e[7:0];
        2: g = {5'h00, flags_out};
        3: g = dir_a_out;
        4: g = dir_b_out;
        5: g = dir_c_out;
        6: g = {7'h00, core_reset_out};
        7: g = {3'h0, file_addr_out};
        8: g = {7'h00, n >= TO && n <= TO + 8};
        default: g = {7'h00, file_we_out};
      endcase
      checks++;
      if (g !== e[7:0])
      begin
        errors++;
        $display("wrong value at %0t: kind %0d got %h exp %h", $time, e[11:8], g, e[7:0]);
      end
    end
  end
  // ==========================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1;
    ex(6, 8'h01);
    @(posedge clk_in);
    master_clear_input_in <= 1;
    wait_run();
    ex(8, 8'h01);
    // swap into acc, then into the file
    repeat (8)
    begin
      r = rnd();
      op({6'h0e, 1'b0, 5'h03}, r);
      acc_m = {r[3:0], r[7:4]};
      ex(0, acc_m);
      ex(2, {5'h00, flags_m});
      r = rnd();
      op({6'h0e, 1'b1, r[4:0]}, r);
      ex(1, {r[3:0], r[7:4]});
      ex(7, {3'h0, r[4:0]});
      ex(0, acc_m);
    end
    // subtract: positive, zero and negative results first
    for (int i = 0; i < 11; i++)
    begin
      b = i < 3 ? 8'h02 : rnd();
      r = i < 3 ? 8'h03 - 8'(i) : rnd();
      op({6'h0e, 1'b0, 5'h01}, {b[3:0], b[7:4]});
      op({6'h02, i[0], 5'h01}, r);
      flags_m = {r == b, r[3:0] >= b[3:0], r >= b};
      if (i[0])
      begin
        ex(1, r - b);
        ex(0, b);
      end
      else
        ex(0, r - b);
      ex(2, {5'h00, flags_m});
    end
    // direction loads: illegal selector first, then 5, 6, 7
    for (int s = 4; s < 8; s++)
    begin
      b = rnd();
      op({6'h0e, 1'b0, 5'h02}, {b[3:0], b[7:4]});
      op({9'h000, 3'(s)}, 8'h00);
      ex(2, {5'h00, flags_m});
      if (s == 4)
      begin
        ex(3, 8'hff);
        ex(5, 8'hff);
      end
      else
        ex(4'(s - 2), b);
    end
    // master clear low mid-run: reset, and writes refused
    @(posedge clk_in);
    master_clear_input_in <= 0;
    repeat (4) @(posedge clk_in);
    op({6'h0e, 1'b1, 5'h00}, 8'h12);
    ex(6, 8'h01);
    ex(9, 8'h00);
    master_clear_input_in <= 1;
    wait_run();
    ex(8, 8'h01);
    // watchdog kept alive by clears, then left to time out
    @(posedge clk_in);
    wdt_enable_in <= 1;
    repeat (3 * TO / 2)
    begin
      @(posedge clk_in);
      wdt_clear_in <= 1;
      @(posedge clk_in);
      wdt_clear_in <= 0;
    end
    ex(6, 8'h00);
    n = 0;
    while (wdt_timeout_out !== 1'b1 && n < 200)
    begin
      @(negedge clk_in);
      n++;
    end
    ex(8, 8'h01);
    @(negedge clk_in);
    ex(6, 8'h01);
    repeat (2) @(negedge clk_in);
    tally_and_finish();
  end
endmodule
`default_nettype wire
